// [src/leism_pkg.sv]
// constants and types of the link error interrupt and resync mask block
package leism_pkg;

	localparam int unsigned NUM_LANES = 8;
	localparam int unsigned AXI_AW    = 16;
	localparam int unsigned AXI_DW    = 32;
	localparam int unsigned CFG_BYTES = 14;

	// register indices; byte address is four times the index
	localparam logic [13:0] IDX_VECTOR    = 14'h047A;
	localparam logic [13:0] IDX_SYNC_MASK = 14'h047B;
	localparam logic [13:0] IDX_THRESH    = 14'h047C;
	localparam logic [13:0] IDX_CNT_CLR   = 14'h0480;

	// field positions
	localparam int unsigned BIT_DISP    = 7;
	localparam int unsigned BIT_NIT     = 6;
	localparam int unsigned BIT_UCC     = 5;
	localparam int unsigned BIT_CMM     = 4;
	localparam int unsigned BIT_CMM_EN  = 3;
	localparam int unsigned BIT_CKSUM   = 2;
	localparam int unsigned BIT_CGS     = 0;
	localparam int unsigned BIT_CNT_CLR = 0;

	// implemented bits of the error vector (flags and masks alike)
	localparam logic [7:0] VEC_USED_MSK = 8'hE5;

	// values after reset, and the counter saturation value
	localparam logic [7:0] RST_FLAGS     = 8'h00;
	localparam logic [7:0] RST_VEC_MASK  = 8'h00;
	localparam logic [2:0] RST_SYNC_MASK = 3'h0;
	localparam logic       RST_CMM_EN    = 1'b1;
	localparam logic [7:0] RST_THRESH    = 8'hFF;
	localparam logic [7:0] RST_COUNT     = 8'h00;
	localparam logic [7:0] COUNT_MAX     = 8'hFF;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef logic [CFG_BYTES*8-1:0] leism_cfg_t;

	// per-lane error reports from the receive lanes
	typedef struct packed {
		logic [NUM_LANES-1:0] disp;     // disparity error, pulse
		logic [NUM_LANES-1:0] nit;      // invalid symbol, pulse
		logic [NUM_LANES-1:0] ucc;      // unexpected control char, pulse
		logic [NUM_LANES-1:0] cksum;    // checksum error, level
		logic [NUM_LANES-1:0] cgs_fail; // char group lock failed, level
	} leism_lane_err_t;

endpackage

// [src/leism_lane_cnt.sv]
// per-lane saturating error counters compared against a threshold
`timescale 1ns/1ps
`default_nettype none
module leism_lane_cnt (
	input  wire logic                           clk,         // core clock
	input  wire logic                           rst_n,       // sync'd reset
	input  wire logic                           ce,          // clock enable
	input  wire logic                           clr,         // clear counts
	input  wire logic [leism_pkg::NUM_LANES-1:0] err,        // error pulses
	input  wire logic [7:0]                     thresh,      // threshold
	output logic                                reached_any  // any lane hit
);
	import leism_pkg::*;

	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		return (v == COUNT_MAX) ? v : v + 8'h01;
	endfunction

	logic [7:0]           cnt_ff [NUM_LANES];
	logic [NUM_LANES-1:0] lane_hit;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_LANES; i++) begin
				cnt_ff[i] <= RST_COUNT;
			end
		end else if (ce) begin
			for (int i = 0; i < NUM_LANES; i++) begin
				if (clr) begin
					cnt_ff[i] <= RST_COUNT;
				end else if (err[i]) begin
					cnt_ff[i] <= sat_inc(cnt_ff[i]); // R12
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_LANES; i++) begin
			lane_hit[i] = (cnt_ff[i] >= thresh); // R12
		end
	end

	assign reached_any = |lane_hit;

	AST_CNT_SAT: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		(cnt_ff[0] == COUNT_MAX) && !clr |=> cnt_ff[0] == COUNT_MAX) // R12
		else $error("lane 0 count left saturation without clear");

	// counts never decay, so a reached threshold stays reached
	AST_CNT_HOLD: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		reached_any && !clr |=> reached_any || $changed(thresh)) // R12
		else $error("threshold hit dropped without clear");

endmodule
`default_nettype wire

// [src/leism_top.sv]
// link error interrupt vector, resync masks and config mismatch flag
// Function
// R1 - checksum error with mask pulls interrupt low
// R2 - vector bit 2 flags checksum error any lane
// R3 - vector bit 0 flags lock failure any lane
// R4 - lock failure with mask pulls interrupt low
// R5 - disparity count at threshold requests resync
// R6 - invalid symbol count at threshold requests resync
// R7 - unexpected control count at threshold requests resync
// R8 - mismatch rise latches flag, pulls interrupt low
// R9 - writing one clears latched mismatch flag
// R10 - mismatch enable low keeps flag inactive
// R11 - mismatch means lane 0 config differs local
// R12 - count errors per lane against threshold
// R13 - mismatch enable comes out of reset set
// R14 - interrupt is OR of flags ANDed masks
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module leism_top (
	input  wire logic                        CORE_CLK,   // 10 MHz clock
	input  wire logic                        RSTN,       // async reset, low
	input  wire logic                        CE,         // clock enable
	input  wire leism_pkg::leism_lane_err_t  LANE_ERR,   // lane errors
	input  wire leism_pkg::leism_cfg_t       LANE0_CFG,  // lane 0 rx config
	input  wire leism_pkg::leism_cfg_t       TX_CFG,     // local tx config
	input  wire logic [15:0]                 AWADDR,     // write address
	input  wire logic                        AWVALID,    // write addr valid
	output logic                             AWREADY,    // write addr ready
	input  wire logic [31:0]                 WDATA,      // write data
	input  wire logic [3:0]                  WSTRB,      // write strobes
	input  wire logic                        WVALID,     // write data valid
	output logic                             WREADY,     // write data ready
	output logic [1:0]                       BRESP,      // write response
	output logic                             BVALID,     // response valid
	input  wire logic                        BREADY,     // response ready
	input  wire logic [15:0]                 ARADDR,     // read address
	input  wire logic                        ARVALID,    // read addr valid
	output logic                             ARREADY,    // read addr ready
	output logic [31:0]                      RDATA,      // read data
	output logic [1:0]                       RRESP,      // read response
	output logic                             RVALID,     // read data valid
	input  wire logic                        RREADY,     // read data ready
	output logic                             IRQ_N,      // interrupt, low
	output logic                             LINK_RESYNC_REQUEST_OUT // resync
);
	import leism_pkg::*;

	function automatic logic idx_hit(input logic [15:0] a,
	                                 input logic [13:0] idx);
		return a[15:2] == idx;
	endfunction

	logic        rst_meta_ff;
	logic        rst_n_ff;
	logic        rst_n;

	logic        awready_ff;
	logic        wready_ff;
	logic        aw_held_ff;
	logic        w_held_ff;
	logic [15:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        arready_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;

	logic [7:0]  flags_ff;
	logic [7:0]  vec_mask_ff;
	logic [2:0]  sync_mask_ff;
	logic        cmm_en_ff;
	logic        cmm_flag_ff;
	logic        mm_prev_ff;
	logic [7:0]  thresh_ff;
	logic        irq_n_ff;
	logic        resync_ff;

	// reset release through two stages
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end
	assign rst_n = rst_n_ff;

	// write channel decode
	wire         aw_take  = AWVALID & awready_ff;
	wire         w_take   = WVALID & wready_ff;
	wire         wr_go    = aw_held_ff & w_held_ff & ~bvalid_ff;
	wire         b_done   = bvalid_ff & BREADY;
	wire         hw_vec   = idx_hit(awaddr_ff, IDX_VECTOR);
	wire         hw_sync  = idx_hit(awaddr_ff, IDX_SYNC_MASK);
	wire         hw_thr   = idx_hit(awaddr_ff, IDX_THRESH);
	wire         hw_clr   = idx_hit(awaddr_ff, IDX_CNT_CLR);
	wire         wr_hit   = hw_vec | hw_sync | hw_thr | hw_clr;
	wire         wr_lane0 = wr_go & wstrb_ff[0];
	wire [7:0]   wb       = wdata_ff[7:0];
	wire         we_vec   = wr_lane0 & hw_vec;
	wire         we_sync  = wr_lane0 & hw_sync;
	wire         we_thr   = wr_lane0 & hw_thr;
	wire         cnt_clr  = wr_lane0 & hw_clr & wb[BIT_CNT_CLR];
	wire         cmm_w1c  = we_sync & wb[BIT_CMM]; // R9

	// read channel decode
	wire         ar_take  = ARVALID & arready_ff;
	wire         r_done   = rvalid_ff & RREADY;
	wire         hr_vec   = idx_hit(ARADDR, IDX_VECTOR);
	wire         hr_sync  = idx_hit(ARADDR, IDX_SYNC_MASK);
	wire         hr_thr   = idx_hit(ARADDR, IDX_THRESH);
	wire         hr_clr   = idx_hit(ARADDR, IDX_CNT_CLR);
	wire         rd_hit   = hr_vec | hr_sync | hr_thr | hr_clr;
	// the vector mask is write only; the vector reads back its flags
	wire [7:0]   sync_rd  = {sync_mask_ff, cmm_flag_ff, cmm_en_ff, 3'h0};
	wire [7:0]   rd_byte  = hr_vec  ? flags_ff :
	                        hr_sync ? sync_rd :
	                        hr_thr  ? thresh_ff : 8'h00;
	wire         rd_vclr  = ar_take & hr_vec;

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			awaddr_ff  <= 16'h0000;
			wdata_ff   <= 32'h0000_0000;
			wstrb_ff   <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
		end else if (CE) begin
			if (aw_take) begin
				awready_ff <= 1'b0;
				aw_held_ff <= 1'b1;
				awaddr_ff  <= AWADDR;
			end
			if (w_take) begin
				wready_ff <= 1'b0;
				w_held_ff <= 1'b1;
				wdata_ff  <= WDATA;
				wstrb_ff  <= WSTRB;
			end
			if (wr_go) begin
				aw_held_ff <= 1'b0;
				w_held_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			// one write at a time: reopen only after the response
			if (b_done) begin
				bvalid_ff  <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= RESP_OKAY;
		end else if (CE) begin
			if (ar_take) begin
				arready_ff <= 1'b0;
				rvalid_ff  <= 1'b1;
				rdata_ff   <= {24'h000000, rd_byte};
				rresp_ff   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (r_done) begin
				rvalid_ff  <= 1'b0;
				arready_ff <= 1'b1;
			end
		end
	end

	// error counters per class
	logic disp_any;
	logic nit_any;
	logic ucc_any;

	leism_lane_cnt u_cnt_disp (
		.clk         (CORE_CLK),
		.rst_n       (rst_n),
		.ce          (CE),
		.clr         (cnt_clr),
		.err         (LANE_ERR.disp),
		.thresh      (thresh_ff),
		.reached_any (disp_any)
	);
	leism_lane_cnt u_cnt_nit (
		.clk         (CORE_CLK),
		.rst_n       (rst_n),
		.ce          (CE),
		.clr         (cnt_clr),
		.err         (LANE_ERR.nit),
		.thresh      (thresh_ff),
		.reached_any (nit_any)
	);
	leism_lane_cnt u_cnt_ucc (
		.clk         (CORE_CLK),
		.rst_n       (rst_n),
		.ce          (CE),
		.clr         (cnt_clr),
		.err         (LANE_ERR.ucc),
		.thresh      (thresh_ff),
		.reached_any (ucc_any)
	);

	wire         cksum_any = |LANE_ERR.cksum;    // R2
	wire         cgs_any   = |LANE_ERR.cgs_fail; // R3
	wire [7:0]   flag_set  = {disp_any, nit_any, ucc_any, 2'b00,
	                          cksum_any, 1'b0, cgs_any};
	// a new event wins over the clear-on-read
	wire [7:0]   nxt_flags = (rd_vclr ? RST_FLAGS : flags_ff) | flag_set;
	wire         mm_now    = (LANE0_CFG != TX_CFG); // R11
	wire         mm_rise   = mm_now & ~mm_prev_ff;  // R8
	// flag held at zero while disabled; a rise beats a write-one clear
	wire         nxt_cmm   = cmm_en_ff &
	                         ((cmm_flag_ff & ~cmm_w1c) | mm_rise); // R8 R9 R10
	wire         vec_irq   = |(flags_ff & vec_mask_ff);      // R1 R4 R14
	wire         nxt_irq_n = ~(vec_irq | (cmm_flag_ff & cmm_en_ff)); // R8
	wire         nxt_resync = |({disp_any, nit_any, ucc_any} &
	                           sync_mask_ff); // R5 R6 R7

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			flags_ff     <= RST_FLAGS;
			vec_mask_ff  <= RST_VEC_MASK;
			sync_mask_ff <= RST_SYNC_MASK;
			cmm_en_ff    <= RST_CMM_EN; // R13
			cmm_flag_ff  <= 1'b0;
			mm_prev_ff   <= 1'b0;
			thresh_ff    <= RST_THRESH;
			irq_n_ff     <= 1'b1;
			resync_ff    <= 1'b0;
		end else if (CE) begin
			flags_ff    <= nxt_flags & VEC_USED_MSK; // R2 R3 R12
			cmm_flag_ff <= nxt_cmm;
			mm_prev_ff  <= mm_now;
			irq_n_ff    <= nxt_irq_n;
			resync_ff   <= nxt_resync;
			if (we_vec) begin
				vec_mask_ff <= wb & VEC_USED_MSK;
			end
			if (we_sync) begin
				sync_mask_ff <= wb[BIT_DISP:BIT_UCC];
				cmm_en_ff    <= wb[BIT_CMM_EN];
			end
			if (we_thr) begin
				thresh_ff <= wb;
			end
		end
	end

	assign AWREADY = awready_ff;
	assign WREADY  = wready_ff;
	assign BVALID  = bvalid_ff;
	assign BRESP   = bresp_ff;
	assign ARREADY = arready_ff;
	assign RVALID  = rvalid_ff;
	assign RDATA   = rdata_ff;
	assign RRESP   = rresp_ff;
	assign IRQ_N   = irq_n_ff;
	assign LINK_RESYNC_REQUEST_OUT = resync_ff;

	AST_CKSUM_IRQ: assert property (@(posedge CORE_CLK)
		disable iff (!rst_n || !CE)
		flags_ff[BIT_CKSUM] && vec_mask_ff[BIT_CKSUM] |=> !IRQ_N) // R1
		else $error("masked checksum flag did not pull interrupt low");

	AST_CKSUM_FLAG: assert property (@(posedge CORE_CLK)
		disable iff (!rst_n || !CE)
		cksum_any |=> flags_ff[BIT_CKSUM] ##1 flags_ff[BIT_CKSUM]
		|| !$past(cksum_any)) // R2
		else $error("checksum error on a lane did not set flag");

	AST_CGS_FLAG: assert property (@(posedge CORE_CLK)
		disable iff (!rst_n || !CE)
		$rose(cgs_any) |=> flags_ff[BIT_CGS]) // R3
		else $error("lock failure did not set its flag");

	AST_CGS_IRQ: assert property (@(posedge CORE_CLK)
		disable iff (!rst_n || !CE)
		cgs_any && vec_mask_ff[BIT_CGS] && !we_vec
		|=> ##1 !IRQ_N) // R4
		else $error("masked lock failure did not reach interrupt");

	AST_DISP_RESYNC: assert property (@(posedge CORE_CLK)
		disable iff (!rst_n || !CE)
		disp_any && sync_mask_ff[2] |=> LINK_RESYNC_REQUEST_OUT) // R5
		else $error("disparity threshold did not request resync");

	AST_NIT_RESYNC: assert property (@(posedge CORE_CLK)
		disable iff (!rst_n || !CE)
		nit_any && sync_mask_ff[1] |=> LINK_RESYNC_REQUEST_OUT) // R6
		else $error("invalid symbol threshold did not request resync");

	AST_UCC_RESYNC: assert property (@(posedge CORE_CLK)
		disable iff (!rst_n || !CE)
		ucc_any && sync_mask_ff[0] |=> LINK_RESYNC_REQUEST_OUT) // R7
		else $error("unexpected control threshold did not request resync");

	AST_CMM_LATCH: assert property (@(posedge CORE_CLK)
		disable iff (!rst_n || !CE)
		cmm_en_ff && mm_rise && !we_sync |=> cmm_flag_ff ##1 !IRQ_N) // R8
		else $error("mismatch rise did not latch and interrupt");

	AST_CMM_W1C: assert property (@(posedge CORE_CLK)
		disable iff (!rst_n || !CE)
		cmm_w1c && !mm_rise |=> !cmm_flag_ff) // R9
		else $error("write one did not clear mismatch flag");

	AST_CMM_OFF: assert property (@(posedge CORE_CLK)
		disable iff (!rst_n || !CE)
		!cmm_en_ff |=> !cmm_flag_ff) // R10
		else $error("mismatch flag active while disabled");

	AST_CMM_CMP: assert property (@(posedge CORE_CLK)
		disable iff (!rst_n || !CE)
		$past(CE) |-> mm_prev_ff == $past(LANE0_CFG != TX_CFG)) // R11
		else $error("mismatch compare does not follow the configs");

	AST_CMM_EN_RST: assert property (@(posedge CORE_CLK)
		disable iff (!rst_n)
		$rose(rst_n) |-> cmm_en_ff) // R13
		else $error("mismatch enable not set after reset");

	AST_IRQ_QUIET: assert property (@(posedge CORE_CLK)
		disable iff (!rst_n || !CE)
		!vec_irq && !(cmm_flag_ff && cmm_en_ff) |=> IRQ_N) // R14
		else $error("interrupt low with no unmasked flag");

endmodule
`default_nettype wire

// [tb/leism_lane_model.sv]
// receive lane and transmitter stand-in: error pulses, levels and config
`timescale 1ns/1ps
`default_nettype none
module leism_lane_model
	import leism_pkg::*;
(
	input  wire logic       clk,      // core clock
	input  wire logic       start,    // load a burst of error pulses
	input  wire logic [1:0] kind,     // 0 disp, 1 invalid sym, 2 ctrl
	input  wire logic [3:0] n,        // pulses in the burst
	input  wire logic       cks_on,   // checksum error level
	input  wire logic       cgs_on,   // char group lock failure level
	input  wire logic       cfg_bad,  // corrupt lane 0 config
	output leism_lane_err_t err,      // lane error reports
	output leism_cfg_t      rx_cfg,   // lane 0 received config
	output leism_cfg_t      tx_cfg    // local transmit config
);
	logic [3:0] cnt_ff = 4'h0;
	logic [7:0] pls;

	// back-to-back pulses on lane 5, the harshest pacing for the counters
	always_ff @(posedge clk) begin
		if (start)
			cnt_ff <= n;
		else if (cnt_ff != 4'h0)
			cnt_ff <= cnt_ff - 4'h1;
	end

	assign pls          = (cnt_ff != 4'h0) ? 8'h20 : 8'h00;
	assign err.disp     = (kind == 2'h0) ? pls : 8'h00;
	assign err.nit      = (kind == 2'h1) ? pls : 8'h00;
	assign err.ucc      = (kind == 2'h2) ? pls : 8'h00;
	assign err.cksum    = cks_on ? 8'h08 : 8'h00;
	assign err.cgs_fail = cgs_on ? 8'h02 : 8'h00;
	assign tx_cfg       = {7{16'hA55A}};
	// only the top bit differs, the far end of the compared range
	assign rx_cfg       = tx_cfg ^ {cfg_bad, 111'h0};
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the link error interrupt and resync block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
	import leism_pkg::*;
	localparam logic [15:0] A_VEC = {IDX_VECTOR, 2'b00};
	localparam logic [15:0] A_SYN = {IDX_SYNC_MASK, 2'b00};
	localparam logic [15:0] A_THR = {IDX_THRESH, 2'b00};
	localparam logic [15:0] A_CLR = {IDX_CNT_CLR, 2'b00};
	logic clk = 0, rstn = 0, ce = 1;
	logic [15:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd_d;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, irq_n, resync;
	logic [1:0] bresp, rresp, rd_r, kind = 0;
	logic [3:0] n = 0, wstrb = 4'hF;
	logic start = 0, cks_on = 0, cgs_on = 0, cfg_bad = 0;
	leism_lane_err_t lane_err;
	leism_cfg_t rx_cfg, tx_cfg;
	int miscompares = 0, n_tests = 0;

	always #50 clk = ~clk;

	leism_lane_model u_leism_lane_model (.clk(clk), .start(start),
		.kind(kind), .n(n), .cks_on(cks_on), .cgs_on(cgs_on),
		.cfg_bad(cfg_bad), .err(lane_err), .rx_cfg(rx_cfg), .tx_cfg(tx_cfg));

	leism_top u_leism_top (.CORE_CLK(clk), .RSTN(rstn), .CE(ce),
		.LANE_ERR(lane_err), .LANE0_CFG(rx_cfg), .TX_CFG(tx_cfg),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
		.ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
		.RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
		.IRQ_N(irq_n), .LINK_RESYNC_REQUEST_OUT(resync));

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic ad, wd;
		ad = 0;
		wd = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ad && wd)) begin
			@(posedge clk);
			ad = ad | (awready === 1'b1);
			wd = wd | (wready === 1'b1);
			awvalid <= !ad;
			wvalid <= !wd;
		end
		while (bvalid !== 1'b1) @(posedge clk);
		bready <= 0;
		`CHK(bresp, RESP_OKAY)
	endtask

	task automatic rd(input logic [15:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		@(posedge clk);
		while (arready !== 1'b1) @(posedge clk);
		arvalid <= 0;
		while (rvalid !== 1'b1) @(posedge clk);
		rd_d = rdata;
		rd_r = rresp;
		rready <= 0;
	endtask

	task automatic rchk(input logic [15:0] a, input logic [31:0] e);
		rd(a);
		`CHK(rd_r, RESP_OKAY)
		`CHK(rd_d, e)
	endtask

	task automatic t_reset;
		`CHK(irq_n, 1'b1)
		rchk(A_SYN, 32'h08);
		rchk(A_THR, 32'hFF);
		// byte lane 0 off: the write is answered but must not land
		wstrb <= 4'hE;
		wr(A_THR, 8'h55);
		wstrb <= 4'hF;
		rchk(A_THR, 32'hFF);
		rchk(A_VEC, 32'h00);
		rd(16'h0000);
		`CHK(rd_r, RESP_SLVERR)
		`CHK(rd_d, 32'h0)
	endtask

	task automatic t_levels;
		wr(A_VEC, 8'h04);
		cks_on <= 1;
		cyc(4);
		`CHK(irq_n, 1'b0)
		rchk(A_VEC, 32'h04);
		cks_on <= 0;
		cyc(3);
		rd(A_VEC);
		rchk(A_VEC, 32'h00);
		cyc(2);
		`CHK(irq_n, 1'b1)
		wr(A_VEC, 8'h00);
		cgs_on <= 1;
		cyc(4);
		`CHK(irq_n, 1'b1)
		rchk(A_VEC, 32'h01);
		wr(A_VEC, 8'h01);
		cyc(3);
		`CHK(irq_n, 1'b0)
		cgs_on <= 0;
		wr(A_VEC, 8'h00);
		rd(A_VEC);
	endtask

	// clock enable low must freeze the flags and the interrupt
	task automatic t_clk_en;
		wr(A_VEC, 8'h04);
		ce <= 0;
		cks_on <= 1;
		cyc(4);
		`CHK(irq_n, 1'b1)
		ce <= 1;
		cyc(3);
		`CHK(irq_n, 1'b0)
		cks_on <= 0;
		rchk(A_VEC, 32'h04);
		wr(A_VEC, 8'h00);
		rd(A_VEC);
	endtask

	task automatic burst(input int k, input logic [3:0] c);
		@(posedge clk);
		kind <= k[1:0];
		n <= c;
		start <= 1;
		@(posedge clk);
		start <= 0;
		cyc(6);
	endtask

	task automatic t_resync;
		wr(A_THR, 8'h03);
		for (int k = 0; k < 3; k++) begin
			wr(A_CLR, 8'h01);
			rd(A_VEC);
			wr(A_SYN, 8'h08 | (8'h80 >> k));
			rchk(A_SYN, 32'h08 | (32'h80 >> k));
			burst(k, 4'h2);
			`CHK(resync, 1'b0)
			burst(k, 4'h1);
			`CHK(resync, 1'b1)
			rchk(A_VEC, 32'h80 >> k);
		end
		wr(A_SYN, 8'h08);
		cyc(3);
		`CHK(resync, 1'b0)
		wr(A_CLR, 8'h01);
		rd(A_VEC);
	endtask

	task automatic t_mismatch;
		cfg_bad <= 1;
		cyc(4);
		`CHK(irq_n, 1'b0)
		rchk(A_SYN, 32'h18);
		wr(A_SYN, 8'h18);
		rchk(A_SYN, 32'h08);
		cyc(2);
		`CHK(irq_n, 1'b1)
		cfg_bad <= 0;
		wr(A_SYN, 8'h00);
		cfg_bad <= 1;
		cyc(4);
		`CHK(irq_n, 1'b1)
		rchk(A_SYN, 32'h00);
		cfg_bad <= 0;
		wr(A_SYN, 8'h08);
	endtask

	task results;
		if (miscompares == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1;
		cyc(3);
		t_reset();
		t_levels();
		t_clk_en();
		t_resync();
		t_mismatch();
		results();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		#(100 * 5000);
		miscompares++;
		results();
	end
endmodule
`default_nettype wire
